// >>> verilog/tcc_defs.svh
`ifndef TCC_DEFS_SVH
`define TCC_DEFS_SVH

// register byte offsets on the apb bus
`define TCC_OFF_SC 12'h000
`define TCC_OFF_CNT 12'h004
`define TCC_OFF_MOD 12'h008
`define TCC_OFF_CH0_CTL 12'h00c
`define TCC_OFF_CH0_VAL 12'h010
`define TCC_OFF_CH1_CTL 12'h014
`define TCC_OFF_CH1_VAL 12'h018

// counter status and control fields
`define TCC_SC_TOF 7
`define TCC_SC_TOIE 6
`define TCC_SC_STOP 5
`define TCC_SC_RST 4
`define TCC_SC_PS_HI 2
`define TCC_SC_PS_LO 0

// channel control field holding the event flag
`define TCC_CH_FLAG 7
// channel control field reserved in channel 1 (link bit position)
`define TCC_CH_LINK 5

// reset values
`define TCC_MOD_RST 16'hffff
`define TCC_STOP_RST 1'b1
`define TCC_PS_RST 3'h0

// widest prescaler divide, as a power of two
`define TCC_PS_MAX_LOG 3'h6

`endif

// >>> verilog/tcc_pkg.sv
package tcc_pkg;

	// apb data word
	typedef logic [31:0] tcc_bus_t;

	// counter and channel value word
	typedef logic [15:0] tcc_word_t;

	// channel control and status byte, msb first
	typedef struct packed {
		logic flag;
		logic ie;
		logic msb;
		logic msa;
		logic elsb;
		logic elsa;
		logic tov;
		logic max;
	} tcc_chctl_t;

	// decoded register select
	typedef enum logic [7:0] {
		TCC_SEL_NONE = 8'h00,
		TCC_SEL_SC = 8'h01,
		TCC_SEL_CNT = 8'h02,
		TCC_SEL_MOD = 8'h04,
		TCC_SEL_C0C = 8'h08,
		TCC_SEL_C0V = 8'h10,
		TCC_SEL_C1C = 8'h20,
		TCC_SEL_C1V = 8'h40
	} tcc_sel_t;

endpackage

// >>> verilog/tcc_prescaler.sv
`timescale 1ns/10ps
`include "tcc_defs.svh"

// divides the bus clock into a one-cycle count enable
module tcc_prescaler (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	input wire logic clear_i,
	input wire logic [2:0] sel_i,
	output logic tick_o
);
	import tcc_pkg::*;

	logic [5:0] div_reg; // free divider
	logic [5:0] div_next;
	logic [2:0] lg; // selected power of two
	logic [5:0] mask;

	////////////////////////////////////////////////////////////////////////
	// select 7 clamps to the widest rate, so every code gives a legal tick
	always_comb begin
		lg = (sel_i > `TCC_PS_MAX_LOG) ? `TCC_PS_MAX_LOG : sel_i;
		mask = 6'((7'h01 << lg) - 7'h01);
		div_next = div_reg;
		tick_o = 1'b0;
		if (clear_i) begin
			div_next = 6'h00;
		end else if (run_i) begin
			div_next = 6'(div_reg + 6'h01);
			tick_o = ((div_reg & mask) == mask);
		end
	end

	// divider register
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			div_reg <= 6'h00;
		end else begin
			div_reg <= div_next;
		end
	end
endmodule

// >>> verilog/tcc_pin_unit.sv
`timescale 1ns/10ps

// one channel pin: edge detection for capture, drive for compare and pwm
module tcc_pin_unit (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic pin_i,
	input wire logic cap_en_i,
	input wire logic oc_en_i,
	input wire logic elsb_i,
	input wire logic elsa_i,
	input wire logic tov_i,
	input wire logic max_i,
	input wire logic ovf_i,
	input wire logic match_i,
	output logic cap_o,
	output logic pin_o,
	output logic pin_oe_o
);
	import tcc_pkg::*;

	logic prev_reg; // pin level last cycle
	logic pin_reg;
	logic oe_reg;
	logic pin_next;
	logic oe_next;
	logic lvl; // level that the pulse holds

	////////////////////////////////////////////////////////////////////////
	// capture edge select and output action
	always_comb begin
		// 01 rising, 10 falling, 11 either edge
		cap_o = cap_en_i & ((elsa_i & pin_i & ~prev_reg) |
			(elsb_i & ~pin_i & prev_reg));
		oe_next = oc_en_i & (elsb_i | elsa_i);
		lvl = ~elsa_i; // pulse is the complement of the compare action
		pin_next = pin_reg;
		if (oc_en_i) begin
			// overflow toggles; with max the pin is pinned to the pulse level
			if (ovf_i && tov_i) begin
				pin_next = max_i ? lvl : ~pin_reg;
			end
			// no tov means compares only re-force the idle level: 0 percent
			if (match_i && !(max_i && tov_i)) begin
				unique case ({elsb_i, elsa_i})
					2'b01: pin_next = ~pin_reg;
					2'b10: pin_next = 1'b0;
					2'b11: pin_next = 1'b1;
					default: pin_next = pin_reg;
				endcase
			end
		end
	end

	// pin state registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			prev_reg <= 1'b0;
			pin_reg <= 1'b0;
			oe_reg <= 1'b0;
		end else begin
			prev_reg <= pin_i;
			pin_reg <= pin_next;
			oe_reg <= oe_next;
		end
	end

	assign pin_o = pin_reg;
	assign pin_oe_o = oe_reg;
endmodule

// >>> verilog/tcc_top.sv
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "tcc_defs.svh"

module tcc_top (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire tcc_pkg::tcc_bus_t pwdata_i,
	output tcc_pkg::tcc_bus_t prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic [1:0] chan_pin_i,
	output logic [1:0] chan_pin_o,
	output logic [1:0] chan_pin_oe_o,
	output logic [1:0] chan_irq_o,
	output logic ovf_irq_o
);
	import tcc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// address decode, shared by the read path and the write path
	function automatic tcc_sel_t tcc_decode(input logic [11:0] a);
		unique case (a)
			`TCC_OFF_SC: tcc_decode = TCC_SEL_SC;
			`TCC_OFF_CNT: tcc_decode = TCC_SEL_CNT;
			`TCC_OFF_MOD: tcc_decode = TCC_SEL_MOD;
			`TCC_OFF_CH0_CTL: tcc_decode = TCC_SEL_C0C;
			`TCC_OFF_CH0_VAL: tcc_decode = TCC_SEL_C0V;
			`TCC_OFF_CH1_CTL: tcc_decode = TCC_SEL_C1C;
			`TCC_OFF_CH1_VAL: tcc_decode = TCC_SEL_C1V;
			default: tcc_decode = TCC_SEL_NONE;
		endcase
	endfunction

	// bus state
	logic pready_reg; // one wait state per access
	logic pready_next;
	tcc_bus_t prdata_reg;
	tcc_bus_t prdata_next;
	logic pslverr_reg;
	logic pslverr_next;
	tcc_sel_t wsel; // register written this cycle
	logic wr; // write takes effect this edge

	// counter state
	logic tof_reg;
	logic tof_next;
	logic toie_reg;
	logic toie_next;
	logic stop_reg; // counter held while set
	logic stop_next;
	logic [2:0] ps_reg;
	logic [2:0] ps_next;
	tcc_word_t cnt_reg;
	tcc_word_t cnt_next;
	tcc_word_t mod_reg;
	tcc_word_t mod_next;
	logic trst; // counter and prescaler restart strobe
	logic tick; // prescaled count enable
	logic ovf; // counter at modulo on a tick
	tcc_word_t cnt_inc; // count that the next tick loads
	logic ovf_irq_reg;

	// channel state
	tcc_chctl_t ctl_reg [2];
	tcc_chctl_t ctl_next [2];
	tcc_word_t val_reg [2];
	tcc_word_t val_next [2];
	logic act1_reg; // linked: channel 1 pair is active
	logic act1_next;
	logic last1_reg; // linked: channel 1 pair written last
	logic last1_next;
	logic [1:0] irq_reg;
	logic [1:0] irq_next;
	logic linked;
	tcc_word_t cmp [2]; // value each channel compares against
	logic [1:0] cap_en;
	logic [1:0] oc_en;
	logic [1:0] match;
	logic [1:0] cap_ev;
	logic [1:0] ev;

	////////////////////////////////////////////////////////////////////////
	// apb slave: access phase waits one cycle, then answers from registers
	always_comb begin
		pready_next = 1'b0;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (psel_i && penable_i && !pready_reg) begin
			pready_next = 1'b1;
			pslverr_next = (tcc_decode(paddr_i) == TCC_SEL_NONE);
			unique case (tcc_decode(paddr_i))
				TCC_SEL_SC: prdata_next = {24'h0000_00, tof_reg, toie_reg, stop_reg,
					2'b00, ps_reg};
				TCC_SEL_CNT: prdata_next = {16'h0000, cnt_reg};
				TCC_SEL_MOD: prdata_next = {16'h0000, mod_reg};
				TCC_SEL_C0C: prdata_next = {24'h0000_00, ctl_reg[0]};
				TCC_SEL_C0V: prdata_next = {16'h0000, val_reg[0]};
				TCC_SEL_C1C: prdata_next = {24'h0000_00, ctl_reg[1]};
				TCC_SEL_C1V: prdata_next = {16'h0000, val_reg[1]};
				default: prdata_next = 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// bus registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= pready_next;
			prdata_reg <= prdata_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// a write lands only at the edge where pready is seen high
	assign wr = psel_i & penable_i & pready_reg & pwrite_i;
	assign wsel = wr ? tcc_decode(paddr_i) : TCC_SEL_NONE;
	assign trst = (wsel == TCC_SEL_SC) & pwdata_i[`TCC_SC_RST];

	////////////////////////////////////////////////////////////////////////
	// prescaler feeding the counter
	tcc_prescaler u_presc (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.run_i(~stop_reg),
		.clear_i(trst),
		.sel_i(ps_reg),
		.tick_o(tick)
	);

	// overflow on the tick that finds the counter at modulo; period is mod+1
	assign ovf = tick & (cnt_reg == mod_reg);
	// a compare fires as the counter reaches its value, so a pulse from
	// overflow (counter back at 0) to value v lasts exactly v ticks
	assign cnt_inc = ovf ? 16'h0000 : 16'(cnt_reg + 16'h0001);

	////////////////////////////////////////////////////////////////////////
	// counter, modulo and counter status
	always_comb begin
		cnt_next = cnt_reg;
		if (trst) begin
			cnt_next = 16'h0000;
		end else if (tick) begin
			cnt_next = cnt_inc;
		end
		mod_next = (wsel == TCC_SEL_MOD) ? pwdata_i[15:0] : mod_reg;
		toie_next = toie_reg;
		stop_next = stop_reg;
		ps_next = ps_reg;
		// writing 0 clears the overflow flag, but a new overflow wins
		tof_next = ovf | tof_reg;
		if (wsel == TCC_SEL_SC) begin
			toie_next = pwdata_i[`TCC_SC_TOIE];
			stop_next = pwdata_i[`TCC_SC_STOP];
			ps_next = pwdata_i[`TCC_SC_PS_HI:`TCC_SC_PS_LO];
			if (!pwdata_i[`TCC_SC_TOF] && !ovf) begin
				tof_next = 1'b0;
			end
		end
	end

	// counter registers
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cnt_reg <= 16'h0000;
			mod_reg <= `TCC_MOD_RST;
			tof_reg <= 1'b0;
			toie_reg <= 1'b0;
			stop_reg <= `TCC_STOP_RST;
			ps_reg <= `TCC_PS_RST;
			ovf_irq_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			mod_reg <= mod_next;
			tof_reg <= tof_next;
			toie_reg <= toie_next;
			stop_reg <= stop_next;
			ps_reg <= ps_next;
			ovf_irq_reg <= tof_next & toie_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// channel modes and compare sources
	assign linked = ctl_reg[0].msb;
	// linked pair: channel 0 reads the active pair's value
	assign cmp[0] = (linked && act1_reg) ? val_reg[1] : val_reg[0];
	assign cmp[1] = val_reg[1];

	generate
		for (genvar c = 0; c < 2; c++) begin : g_ch
			// channel 1 is off while linked, its pin given back
			logic on;
			assign on = (c == 0) | ~linked;
			// mode 00 with an edge chosen is capture; any nonzero mode is compare
			assign cap_en[c] = on & ~ctl_reg[c].msb & ~ctl_reg[c].msa &
				(ctl_reg[c].elsb | ctl_reg[c].elsa);
			assign oc_en[c] = on & (ctl_reg[c].msb | ctl_reg[c].msa);
			// equality only: a value already passed waits a full period
			assign match[c] = tick & oc_en[c] & (cnt_inc == cmp[c]);
			assign ev[c] = match[c] | cap_ev[c];

			tcc_pin_unit u_pin (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.pin_i(chan_pin_i[c]),
				.cap_en_i(cap_en[c]),
				.oc_en_i(oc_en[c]),
				.elsb_i(ctl_reg[c].elsb),
				.elsa_i(ctl_reg[c].elsa),
				.tov_i(ctl_reg[c].tov),
				.max_i(ctl_reg[c].max),
				.ovf_i(ovf),
				.match_i(match[c]),
				.cap_o(cap_ev[c]),
				.pin_o(chan_pin_o[c]),
				.pin_oe_o(chan_pin_oe_o[c])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// channel registers, flags and buffer selection
	always_comb begin
		for (int c = 0; c < 2; c++) begin
			ctl_next[c] = ctl_reg[c];
			val_next[c] = val_reg[c];
		end
		// control writes; flag clears on a written 0, an event wins
		if (wsel == TCC_SEL_C0C) begin
			ctl_next[0] = tcc_chctl_t'(pwdata_i[7:0]);
			ctl_next[0].flag = ctl_reg[0].flag & pwdata_i[`TCC_CH_FLAG];
		end
		if (wsel == TCC_SEL_C1C) begin
			ctl_next[1] = tcc_chctl_t'(pwdata_i[7:0]);
			ctl_next[1].flag = ctl_reg[1].flag & pwdata_i[`TCC_CH_FLAG];
			ctl_next[1].msb = 1'b0; // link bit exists on channel 0 only
		end
		for (int c = 0; c < 2; c++) begin
			ctl_next[c].flag = ctl_next[c].flag | ev[c];
		end
		// value writes go straight to the compare value, no shadow
		if (wsel == TCC_SEL_C0V) begin
			val_next[0] = pwdata_i[15:0];
		end
		if (wsel == TCC_SEL_C1V) begin
			val_next[1] = pwdata_i[15:0];
		end
		// a capture beats a simultaneous software write
		for (int c = 0; c < 2; c++) begin
			if (cap_ev[c]) begin
				val_next[c] = cnt_reg;
			end
		end
		// remember which pair was written last
		last1_next = linked & last1_reg;
		if (wsel == TCC_SEL_C1V) begin
			last1_next = 1'b1;
		end else if (wsel == TCC_SEL_C0V) begin
			last1_next = 1'b0;
		end
		// swap happens only at overflow, so a period is never split
		act1_next = 1'b0;
		if (linked) begin
			act1_next = ovf ? last1_reg : act1_reg;
		end
		for (int c = 0; c < 2; c++) begin
			irq_next[c] = ctl_next[c].flag & ctl_next[c].ie;
		end
	end

	// channel registers; values have no defined reset, zero is used
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int c = 0; c < 2; c++) begin
				ctl_reg[c] <= '0;
				val_reg[c] <= 16'h0000;
			end
			act1_reg <= 1'b0;
			last1_reg <= 1'b0;
			irq_reg <= 2'b00;
		end else begin
			for (int c = 0; c < 2; c++) begin
				ctl_reg[c] <= ctl_next[c];
				val_reg[c] <= val_next[c];
			end
			act1_reg <= act1_next;
			last1_reg <= last1_next;
			irq_reg <= irq_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all from registers
	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;
	assign chan_irq_o = irq_reg;
	assign ovf_irq_o = ovf_irq_reg;
endmodule

// >>> test/tcc_top_asserts.sv
`timescale 1ns/10ps
`include "tcc_defs.svh"

// watches the apb side and the channel pin enables of the timer block
module tcc_top_asserts (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire tcc_pkg::tcc_bus_t pwdata_i,
	input wire tcc_pkg::tcc_bus_t prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic [1:0] chan_pin_oe_o,
	input wire logic [1:0] chan_irq_o
);
	import tcc_pkg::*;
	logic [7:0] ctl0_reg; // shadow of the last byte written to channel 0 control
	logic [7:0] ctl0_next;

	////////////////////////////////////////////////////////////////
	// follow completed writes so pin enables can be judged from the bus alone
	always_comb begin
		ctl0_next = ctl0_reg;
		if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o
			&& paddr_i == `TCC_OFF_CH0_CTL) begin
			ctl0_next = pwdata_i[7:0];
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ctl0_reg <= 8'h00;
		end else begin
			ctl0_reg <= ctl0_next;
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	a_ready_wait: assert property (psel_i && !penable_i ##1 psel_i && penable_i
		|-> !pready_o ##1 pready_o) else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	a_slverr_ready: assert property (pslverr_o |-> pready_o)
		else $error("pslverr without pready");
	a_ready_access: assert property (pready_o |-> psel_i && penable_i)
		else $error("pready outside an access phase");
	a_rdata_hold: assert property ($changed(prdata_o) |-> pready_o)
		else $error("read data moved between answers");
	a_bad_rdata: assert property (pslverr_o && !pwrite_i |-> prdata_o == 32'h0000_0000)
		else $error("refused read returned data");
	// linked channels leave channel 1 undriven
	a_ch1_release: assert property (ctl0_reg[5] && $past(ctl0_reg[5])
		|-> !chan_pin_oe_o[1]) else $error("channel 1 pin driven while linked");
	// compare mode with an action drives channel 0
	a_ch0_enable: assert property (ctl0_reg == $past(ctl0_reg)
		|-> chan_pin_oe_o[0] == (ctl0_reg[5:4] != 2'b00 && ctl0_reg[3:2] != 2'b00))
		else $error("channel 0 drive does not follow its mode");
	a_irq_enable: assert property (chan_irq_o[0]
		|-> ctl0_reg[6] || $past(ctl0_reg[6])) else $error("channel 0 irq without enable");
endmodule

// >>> test/tcc_pin_env.sv
`timescale 1ns/10ps

// outside world of the two channel pins: a source per pin, overridden
// while the block drives; a released pin shows the source again
module tcc_pin_env (
	input wire logic [1:0] ext_lvl_i, // level the outside sources drive
	input wire logic [1:0] drv_i, // block drive value
	input wire logic [1:0] oe_i, // block drive enable
	output logic [1:0] pin_o // resolved pin level
);
	// resolve each pin; channel 1 falls back to the source when linked
	always_comb begin
		pin_o = ext_lvl_i;
		for (int k = 0; k < 2; k++) begin
			if (oe_i[k]) begin
				pin_o[k] = drv_i[k];
			end
		end
	end
endmodule

// >>> test/tb_top.sv
`timescale 1ns/10ps
`include "tcc_defs.svh"

// self-checking bench: apb master tasks, pin sources, one task per scenario
module tb_top;
	import tcc_pkg::*;
	logic clk_i, sys_rst_i, psel, penable, pwrite, pready, pslverr, ovf_irq;
	logic [11:0] paddr;
	tcc_bus_t pwdata, prdata;
	logic [1:0] pin_in, pin_out, pin_oe, ext_lvl, chan_irq;
	int n_errors, tests_run, cyc, t0, t1, t2;
	tcc_bus_t rd; // data of the last read
	logic err; // error answer of the last transfer

	tcc_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .chan_pin_i(pin_in),
		.chan_pin_o(pin_out), .chan_pin_oe_o(pin_oe), .chan_irq_o(chan_irq),
		.ovf_irq_o(ovf_irq));
	tcc_pin_env i_pins (.ext_lvl_i(ext_lvl), .drv_i(pin_out), .oe_i(pin_oe), .pin_o(pin_in));

	////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	// cycle count on the falling edge so edge-time reads never race it
	always @(negedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// one apb transfer; waits for pready with no assumed latency
	task automatic apb(input logic wr, input logic [11:0] a, input logic [15:0] d);
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge clk_i);
		penable <= 1'b1;
		forever begin
			@(posedge clk_i);
			if (pready === 1'b1) break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic setpin(input logic v);
		@(posedge clk_i);
		ext_lvl[0] <= v;
		repeat (5) @(posedge clk_i);
	endtask

	// cycle stamp of the first edge where channel 0 shows v
	task automatic waitpin(input logic v, output int t);
		forever begin
			@(posedge clk_i);
			if (pin_out[0] === v) break;
		end
		t = cyc;
	endtask

	task automatic hold(input logic v, input int n);
		int k;
		k = 0;
		repeat (n) begin
			@(posedge clk_i);
			if (pin_out[0] !== v) k++;
		end
		chk("pin steady", 0, 32'(k));
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_regs();
		apb(0, `TCC_OFF_SC, 16'h0000);
		chk("sc reset", 32'h0000_0020, rd);
		apb(0, `TCC_OFF_MOD, 16'h0000);
		chk("mod reset", 32'h0000_ffff, rd);
		apb(0, 12'h01c, 16'h0000);
		chk("unmapped err", 32'h0000_0001, 32'(err));
		chk("unmapped data", 32'h0000_0000, rd);
		apb(1, `TCC_OFF_CH1_CTL, 16'h0020);
		apb(0, `TCC_OFF_CH1_CTL, 16'h0000);
		chk("ch1 link bit", 32'h0000_0000, rd);
		$display("test regs done");
	endtask

	// stopped counter makes the captured value known
	task automatic t_capture();
		logic [15:0] c;
		apb(1, `TCC_OFF_SC, 16'h0000);
		repeat (30) @(posedge clk_i);
		apb(1, `TCC_OFF_SC, 16'h0020);
		apb(0, `TCC_OFF_CNT, 16'h0000);
		c = rd[15:0];
		for (int e = 1; e < 4; e++) begin
			apb(1, `TCC_OFF_CH0_CTL, 16'h0040 | 16'(e << 2));
			apb(1, `TCC_OFF_CH0_VAL, 16'h0000);
			setpin(1'b1);
			chk("irq after rise", 32'(e % 2), 32'(chan_irq[0]));
			setpin(1'b0);
			chk("irq after fall", 32'h0000_0001, 32'(chan_irq[0]));
			apb(0, `TCC_OFF_CH0_VAL, 16'h0000);
			chk("captured value", 32'(c), rd);
		end
		apb(1, `TCC_OFF_CH0_CTL, 16'h0000);
		repeat (3) @(posedge clk_i);
		chk("irq cleared", 32'h0000_0000, 32'(chan_irq[0]));
		$display("test capture done");
	endtask

	task automatic t_compare();
		logic p;
		apb(1, `TCC_OFF_MOD, 16'h0013);
		apb(1, `TCC_OFF_CH0_VAL, 16'h0005);
		// restart the counter: the capture test left it above the new modulo
		apb(1, `TCC_OFF_SC, 16'h0050);
		apb(1, `TCC_OFF_CH0_CTL, 16'h001c);
		apb(1, `TCC_OFF_CH1_VAL, 16'h0003);
		apb(1, `TCC_OFF_CH1_CTL, 16'h005c);
		repeat (25) @(posedge clk_i);
		chk("set on match", 32'h0000_0001, 32'(pin_out[0]));
		chk("ch1 set on match", 32'h0000_0001, 32'(pin_out[1]));
		chk("ch1 match irq", 32'h0000_0001, 32'(chan_irq[1]));
		chk("overflow irq", 32'h0000_0001, 32'(ovf_irq));
		apb(0, `TCC_OFF_CH0_CTL, 16'h0000);
		chk("match flag", 32'h0000_0001, 32'(rd[7]));
		apb(1, `TCC_OFF_CH0_CTL, 16'h0018);
		repeat (25) @(posedge clk_i);
		chk("clear on match", 32'h0000_0000, 32'(pin_out[0]));
		apb(1, `TCC_OFF_CH0_CTL, 16'h0014);
		for (int s = 0; s < 2; s++) begin
			apb(1, `TCC_OFF_SC, s ? 16'h0007 : 16'h0000);
			p = pin_out[0];
			waitpin(~p, t0);
			waitpin(p, t1);
			chk("toggle interval", s ? 32'd1280 : 32'd20, 32'(t1 - t0));
		end
		$display("test compare done");
	endtask

	task automatic t_pwm();
		apb(1, `TCC_OFF_SC, 16'h0030);
		apb(1, `TCC_OFF_MOD, 16'h00ff);
		apb(1, `TCC_OFF_CH0_VAL, 16'h0080);
		apb(1, `TCC_OFF_CH0_CTL, 16'h001a);
		apb(1, `TCC_OFF_SC, 16'h0000);
		// the toggle test leaves the pin at either level: sync on a low first
		waitpin(1'b0, t0);
		waitpin(1'b1, t0);
		waitpin(1'b0, t1);
		chk("pwm width", 32'd128, 32'(t1 - t0));
		// shorter pulse written just after its compare, counter already past it
		apb(1, `TCC_OFF_CH0_VAL, 16'h0040);
		waitpin(1'b1, t2);
		chk("pwm period", 32'd256, 32'(t2 - t0));
		waitpin(1'b0, t1);
		chk("direct value", 32'd64, 32'(t1 - t2));
		// longer pulse written just after the overflow
		waitpin(1'b1, t2);
		apb(1, `TCC_OFF_CH0_VAL, 16'h0080);
		waitpin(1'b0, t1);
		chk("raised value", 32'd128, 32'(t1 - t2));
		apb(1, `TCC_OFF_CH0_CTL, 16'h001b);
		repeat (300) @(posedge clk_i);
		hold(1'b1, 300);
		apb(1, `TCC_OFF_CH0_CTL, 16'h0018);
		repeat (300) @(posedge clk_i);
		hold(1'b0, 300);
		$display("test pwm done");
	endtask

	task automatic t_link();
		apb(1, `TCC_OFF_CH0_VAL, 16'h0080);
		apb(1, `TCC_OFF_CH0_CTL, 16'h002a);
		apb(1, `TCC_OFF_CH1_CTL, 16'h001c);
		waitpin(1'b0, t0);
		waitpin(1'b1, t0);
		apb(1, `TCC_OFF_CH1_VAL, 16'h0040);
		waitpin(1'b0, t1);
		chk("first pair", 32'd128, 32'(t1 - t0));
		waitpin(1'b1, t2);
		waitpin(1'b0, t1);
		chk("second pair", 32'd64, 32'(t1 - t2));
		chk("ch1 released", 32'h0000_0000, 32'(pin_oe[1]));
		$display("test link done");
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		sys_rst_i = 1'b1;
		{psel, penable, pwrite} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		ext_lvl = 2'h0;
		{n_errors, tests_run, cyc} = {32'h0, 32'h0, 32'h0};
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		t_regs();
		t_capture();
		t_compare();
		t_pwm();
		t_link();
		report_and_stop();
	end
endmodule

bind tcc_top tcc_top_asserts i_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.chan_pin_oe_o(chan_pin_oe_o), .chan_irq_o(chan_irq_o));
